// [ofm_pkg.sv]
// Purpose: shared constants and types of the oscillator fail monitor
// Assumes: 100 MHz system clock, 16-bit register port
// Notes:   one package for the whole block

package ofm_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int OFM_CLK_MHZ = 100;
    localparam int OFM_OVF_TICKS = 16;
    // dead time between dropping one clock source and starting another
    localparam int OFM_GAP_NS = 40;
    localparam int OFM_GAP_CYC = (OFM_GAP_NS * OFM_CLK_MHZ + 999) / 1000;
    localparam int OFM_TICK_DIV = 4;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int OFM_AW = 4;
    localparam int OFM_DW = 16;
    localparam logic [3:0] OFM_CFG_OFS = 4'h0;
    localparam logic [3:0] OFM_STAT_OFS = 4'h4;
    localparam int OFM_DIS_BIT = 4;
    localparam int OFM_FAIL_BIT = 0;
    localparam int OFM_IRQ_BIT = 1;
    localparam int OFM_STATE_LSB = 2;
    localparam int OFM_STRAP_LSB = 4;
    localparam int OFM_MULT_LSB = 8;
    localparam logic OFM_DIS_RST = 1'b0;

    // ----------------------------------------------------------------
    // strap codes and multiplication factors
    // ----------------------------------------------------------------
    localparam logic [2:0] OFM_STRAP_DIRECT = 3'h3;
    localparam logic [2:0] OFM_STRAP_PRESC = 3'h1;
    localparam logic [2:0] OFM_STRAP_X3 = 3'h6;
    localparam logic [2:0] OFM_STRAP_X5 = 3'h4;
    localparam logic [2:0] OFM_MULT_X3 = 3'h3;
    localparam logic [2:0] OFM_MULT_X5 = 3'h5;
    localparam logic [2:0] OFM_MULT_OTHER = 3'h4;
    localparam logic [2:0] OFM_MULT_NONE = 3'h0;
    localparam logic [1:0] OFM_POST_DIV = 2'h2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OFM_ST_RUN = 2'b00,
        OFM_ST_GAP = 2'b01,
        OFM_ST_FAIL = 2'b10
    } ofm_state_t;

    typedef enum logic [1:0] {
        OFM_SRC_DIRECT = 2'b00,
        OFM_SRC_PRESC = 2'b01,
        OFM_SRC_PLL = 2'b10,
        OFM_SRC_FREE = 2'b11
    } ofm_src_t;

    typedef struct packed {
        ofm_src_t src;
        logic gate_off;
        logic pll_power;
        logic pll_free;
        logic [2:0] mult;
        logic [1:0] post_div;
    } ofm_clk_ctrl_t;

endpackage

// [ofm_monitor.sv]
// Purpose: clock loss monitor, cpu clock source select and pll straps
// Assumes: crystal and strap pins are asynchronous to clk; the free
//          running pll rate is modelled as a tick every TICK_DIV clocks
// Notes:   all design state lives in one struct registered by one always_ff; the checks keep rst_q in a second one
//
// Behaviour
// - monitor is enabled after reset with no software action
// - writing one to config bit 4 turns the monitor off
// - monitor only works when cpu runs direct or prescaled
// - while enabled the free pll runs; each pll cycle adds one
// - every crystal transition clears the monitor counter
// - sixteen pll cycles without a crystal edge means oscillator failure
// - on failure the cpu clock moves to the free running pll
// - on failure the monitor interrupt request flag is set
// - after switchover the cpu stays on pll even if crystal returns
// - only hardware or bidirectional reset restores the direct clock
// - with monitor off in direct or prescaled mode the cpu runs from the crystal unless a failure already moved it to the free pll
// - with monitor off the pll is powered down, except in pll strap modes or after a failure
// - non direct strap codes enable pll and clock cpu from it
// - pll factor comes from the three straps latched at reset
// - strap code 110 selects factor three
// - strap code 100 selects factor five
// - pll output is the oscillator stage divided by two
// - enabled monitor gets free pll clock; disabled monitor turns pll off in direct or prescaled mode unless a failure is latched
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps

module ofm_monitor
    import ofm_pkg::*;
#(
    parameter int TICK_DIV = OFM_TICK_DIV
) (
    input wire logic clk,                    // 100 MHz system clock
    input wire logic reset,                  // hardware reset, sync
    input wire logic bidir_reset,            // sw / watchdog bidir reset
    input wire logic crystal_input_pin,      // external oscillator level
    input wire logic [2:0] clock_mode_strap_pins, // mode straps
    input wire logic [OFM_AW-1:0] addr,      // register address
    input wire logic [OFM_DW-1:0] wdata,     // write data
    input wire logic wr,                     // write strobe
    input wire logic rd,                     // read strobe
    output logic [OFM_DW-1:0] rdata,         // read data, cycle after rd
    output ofm_clk_ctrl_t clk_ctrl,          // cpu clock and pll control
    output logic monitor_irq,                // interrupt request flag
    output logic osc_fail                    // latched failure indication
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] xs;
        logic xf;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] strap;
        logic cfg_dis;
        ofm_state_t state;
        logic [4:0] cnt;
        logic [3:0] gap;
        logic [7:0] div;
        logic tick;
        logic irq;
        logic fail;
        logic [OFM_DW-1:0] rdata;
        ofm_clk_ctrl_t ctrl;
    } ofm_regs_t;

    ofm_regs_t r_q;
    ofm_regs_t r_d;

    logic rst_any;
    logic x_edge;
    logic direct;
    logic mon_on;

    function automatic logic [2:0] ofm_factor(input logic [2:0] code);
        logic [2:0] f;
        f = OFM_MULT_OTHER;
        if (code == OFM_STRAP_X3) begin
            f = OFM_MULT_X3;
        end else if (code == OFM_STRAP_X5) begin
            f = OFM_MULT_X5;
        end
        return f;
    endfunction

    function automatic logic ofm_is_direct(input logic [2:0] code);
        return (code == OFM_STRAP_DIRECT) || (code == OFM_STRAP_PRESC);
    endfunction

    // control word is built from the next state and registered along with it
    function automatic ofm_clk_ctrl_t ofm_ctrl(input ofm_regs_t s);
        ofm_clk_ctrl_t c;
        logic dir;
        dir = ofm_is_direct(s.strap);
        c.src = (s.strap == OFM_STRAP_PRESC) ? OFM_SRC_PRESC
                                             : OFM_SRC_DIRECT;
        c.gate_off = 1'b0;
        c.pll_power = 1'b0;
        c.pll_free = 1'b0;
        c.mult = OFM_MULT_NONE;
        c.post_div = OFM_POST_DIV;
        unique case (s.state)
            OFM_ST_RUN: begin
                if (!dir) begin
                    c.src = OFM_SRC_PLL;
                    c.pll_power = 1'b1;
                    c.mult = ofm_factor(s.strap);
                end else if (!s.cfg_dis) begin
                    c.pll_power = 1'b1;
                    c.pll_free = 1'b1;
                end
                // disabled monitor: crystal clock, pll off
            end
            OFM_ST_GAP: begin
                // old source gated before the new one starts
                c.gate_off = 1'b1;
                c.pll_power = 1'b1;
                c.pll_free = 1'b1;
            end
            OFM_ST_FAIL: begin
                c.src = OFM_SRC_FREE;
                c.pll_power = 1'b1;
                c.pll_free = 1'b1;
            end
            default: begin
                c.gate_off = 1'b1;
            end
        endcase
        return c;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        rst_any = reset || bidir_reset;
        r_d.tick = 1'b0;
        r_d.rdata = '0;

        // crystal sync: a change counts once stages two and three agree
        r_d.xs = {r_q.xs[1:0], crystal_input_pin};
        x_edge = (r_q.xs[1] == r_q.xs[2]) && (r_q.xs[2] != r_q.xf);
        if (x_edge) begin
            r_d.xf = r_q.xs[2];
        end
        r_d.s1 = clock_mode_strap_pins;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;

        direct = ofm_is_direct(r_q.strap);
        mon_on = direct && !r_q.cfg_dis
                 && (r_q.state == OFM_ST_RUN);

        // free running pll cycle, only while pll_free is set
        if (r_q.ctrl.pll_free) begin
            if (r_q.div == 8'(TICK_DIV - 1)) begin
                r_d.div = 8'h00;
                r_d.tick = 1'b1;
            end else begin
                r_d.div = r_q.div + 8'h01;
            end
        end else begin
            r_d.div = 8'h00;
        end

        // register writes before the monitor so a failure beats the clear
        if (wr && addr == OFM_CFG_OFS) begin
            r_d.cfg_dis = wdata[OFM_DIS_BIT];
        end
        if (wr && addr == OFM_STAT_OFS && wdata[OFM_IRQ_BIT]) begin
            r_d.irq = 1'b0;
        end
        if (rd && addr == OFM_CFG_OFS) begin
            r_d.rdata[OFM_DIS_BIT] = r_q.cfg_dis;
        end
        if (rd && addr == OFM_STAT_OFS) begin
            r_d.rdata[OFM_FAIL_BIT] = r_q.fail;
            r_d.rdata[OFM_IRQ_BIT] = r_q.irq;
            r_d.rdata[OFM_STATE_LSB +: 2] = r_q.state;
            r_d.rdata[OFM_STRAP_LSB +: 3] = r_q.strap;
            r_d.rdata[OFM_MULT_LSB +: 3] = r_q.ctrl.mult;
        end

        // monitor counter
        unique case (r_q.state)
            OFM_ST_RUN: begin
                if (!mon_on) begin
                    r_d.cnt = 5'h00;
                end else if (x_edge) begin
                    r_d.cnt = 5'h00;
                end else if (r_q.tick) begin
                    if (r_q.cnt == 5'(OFM_OVF_TICKS - 1)) begin
                        r_d.cnt = 5'h00;
                        r_d.state = OFM_ST_GAP;
                        r_d.gap = 4'h0;
                        r_d.fail = 1'b1;
                        r_d.irq = 1'b1;
                    end else begin
                        r_d.cnt = r_q.cnt + 5'h01;
                    end
                end
            end
            OFM_ST_GAP: begin
                r_d.cnt = 5'h00;
                if (r_q.gap == 4'(OFM_GAP_CYC - 1)) begin
                    r_d.state = OFM_ST_FAIL;
                end else begin
                    r_d.gap = r_q.gap + 4'h1;
                end
            end
            OFM_ST_FAIL: begin
                // crystal activity is ignored from here on
                r_d.cnt = 5'h00;
            end
            default: begin
                r_d.state = OFM_ST_FAIL;
            end
        endcase

        // straps are caught while reset is held, once the sync settles
        if (rst_any) begin
            if (r_q.s2 == r_q.s3) begin
                r_d.strap = r_q.s3;
            end
            r_d.cfg_dis = OFM_DIS_RST;
            r_d.state = OFM_ST_RUN;
            r_d.cnt = 5'h00;
            r_d.gap = 4'h0;
            r_d.div = 8'h00;
            r_d.tick = 1'b0;
            r_d.irq = 1'b0;
            r_d.fail = 1'b0;
            r_d.rdata = '0;
        end
        r_d.ctrl = ofm_ctrl(r_d);
    end

    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    assign rdata = r_q.rdata;
    assign clk_ctrl = r_q.ctrl;
    assign monitor_irq = r_q.irq;
    assign osc_fail = r_q.fail;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic rst_q;
    always_ff @(posedge clk) begin
        rst_q <= reset || bidir_reset;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || bidir_reset);

    property p_reset_state;
        @(posedge clk) disable iff (1'b0)
        (reset || bidir_reset) |=> (!r_q.cfg_dis && !r_q.fail
            && r_q.state == OFM_ST_RUN && r_q.cnt == 5'h00
            && clk_ctrl.src != OFM_SRC_FREE);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset did not restore monitor and direct clock");

    property p_disable_write;
        wr && addr == OFM_CFG_OFS && wdata[OFM_DIS_BIT] |=> r_q.cfg_dis;
    endproperty
    a_disable_write: assert property (p_disable_write)
        else $error("disable bit not taken");

    property p_pll_mode_idle;
        !ofm_is_direct(r_q.strap) |-> r_q.cnt == 5'h00 && !r_q.fail;
    endproperty
    a_pll_mode_idle: assert property (p_pll_mode_idle)
        else $error("monitor active while pll multiplies");

    property p_count_up;
        mon_on && r_q.tick && !x_edge && r_q.cnt < 5'h0F
            |=> r_q.cnt == $past(r_q.cnt) + 5'h01;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not advance on pll tick");

    property p_edge_clear;
        mon_on && x_edge |=> r_q.cnt == 5'h00;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("crystal edge did not clear counter");

    property p_overflow;
        mon_on && r_q.tick && !x_edge && r_q.cnt == 5'h0F
            |=> r_q.state == OFM_ST_GAP && osc_fail && monitor_irq;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not flag failure");

    sequence s_gated;
        clk_ctrl.gate_off [*4];
    endsequence
    sequence s_on_free;
        clk_ctrl.src == OFM_SRC_FREE && !clk_ctrl.gate_off;
    endsequence
    property p_switchover;
        $rose(osc_fail) |-> s_gated ##1 s_on_free;
    endproperty
    a_switchover: assert property (p_switchover)
        else $error("switchover sequence wrong");

    property p_stay_free;
        r_q.state == OFM_ST_FAIL |=> clk_ctrl.src == OFM_SRC_FREE
            && osc_fail;
    endproperty
    a_stay_free: assert property (p_stay_free)
        else $error("left free running clock without reset");

    property p_disabled_off;
        direct && r_q.cfg_dis && r_q.state == OFM_ST_RUN
            |-> !clk_ctrl.pll_power && clk_ctrl.src != OFM_SRC_PLL
            && clk_ctrl.src != OFM_SRC_FREE;
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("disabled monitor left pll or wrong source");

    property p_pll_select;
        !rst_q && !direct |-> clk_ctrl.src == OFM_SRC_PLL
            && clk_ctrl.pll_power && clk_ctrl.mult == ofm_factor(r_q.strap);
    endproperty
    a_pll_select: assert property (p_pll_select)
        else $error("pll mode not selected from straps");

    property p_factors;
        !rst_q && !direct |-> (r_q.strap != OFM_STRAP_X3
            || clk_ctrl.mult == 3'h3) && (r_q.strap != OFM_STRAP_X5
            || clk_ctrl.mult == 3'h5) && clk_ctrl.post_div == 2'h2;
    endproperty
    a_factors: assert property (p_factors)
        else $error("pll factor or post divider wrong");

    property p_monitor_clock;
        !rst_q && mon_on |-> clk_ctrl.pll_power && clk_ctrl.pll_free;
    endproperty
    a_monitor_clock: assert property (p_monitor_clock)
        else $error("enabled monitor without free pll clock");

endmodule

// [ofm_xtal_model.sv]
// Purpose: external crystal oscillator seen at the crystal input pin
// Assumes: pin level changes only on rising clk edges
// Notes:   a stopped oscillator holds its last level, as a dead crystal does
`timescale 1ns/1ps

module ofm_xtal_model #(
    parameter int HALF = 5 // half period in clk cycles
) (
    input wire logic clk,  // system clock
    input wire logic run,  // oscillator running
    output logic pin       // crystal input pin level
);
    int cnt = 0;

    initial pin = 1'b0;

    // ----------------------------------------------------------------
    // oscillation
    // ----------------------------------------------------------------
    // rate kept well inside what the monitor accepts as a live clock
    always_ff @(posedge clk) begin
        if (run) begin
            if (cnt == HALF - 1) begin
                cnt <= 0;
                pin <= ~pin;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// [ofm_monitor_tb.sv]
// Purpose: self-checking bench of the oscillator fail monitor
// Assumes: tick divider shortened to 2 to keep detection runs short
// Notes:   crystal model is stopped right after one of its own edges
`timescale 1ns/1ps

module ofm_monitor_tb;
    import ofm_pkg::*;
    localparam int TD = 2;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic bidir_reset = 1'b0;
    logic xrun = 1'b1;
    logic xtal;
    logic [2:0] strap = OFM_STRAP_DIRECT;
    logic [OFM_AW-1:0] addr = '0;
    logic [OFM_DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [OFM_DW-1:0] rdata;
    ofm_clk_ctrl_t clk_ctrl;
    logic monitor_irq;
    logic osc_fail;
    int num_errors = 0;
    int checks = 0;
    int n;
    int i;
    logic live;

    initial begin
        forever #5 clk = ~clk;
    end

    ofm_monitor #(.TICK_DIV(TD)) ofm_monitor_inst (
        .clk(clk), .reset(reset), .bidir_reset(bidir_reset),
        .crystal_input_pin(xtal), .clock_mode_strap_pins(strap),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .clk_ctrl(clk_ctrl), .monitor_irq(monitor_irq), .osc_fail(osc_fail)
    );

    ofm_xtal_model #(.HALF(5)) ofm_xtal_model_inst (
        .clk(clk), .run(xrun), .pin(xtal)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    // the chosen reset is held alone for 8 cycles so the straps settle
    task automatic do_reset(input logic [2:0] code, input logic bidir);
        strap <= code;
        if (bidir) bidir_reset <= 1'b1;
        else reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        bidir_reset <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic stop_xtal();
        @(xtal);
        xrun <= 1'b0;
    endtask

    function automatic logic [1:0] exp_src(input logic [2:0] c);
        if (c == OFM_STRAP_DIRECT) return OFM_SRC_DIRECT;
        if (c == OFM_STRAP_PRESC) return OFM_SRC_PRESC;
        return OFM_SRC_PLL;
    endfunction

    function automatic logic [2:0] exp_mult(input logic [2:0] c);
        if (c == OFM_STRAP_DIRECT || c == OFM_STRAP_PRESC) return OFM_MULT_NONE;
        if (c == OFM_STRAP_X3) return OFM_MULT_X3;
        if (c == OFM_STRAP_X5) return OFM_MULT_X5;
        return OFM_MULT_OTHER;
    endfunction

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        do_reset(OFM_STRAP_DIRECT, 1'b0);
        chk("src", 16'(clk_ctrl.src), 16'(OFM_SRC_DIRECT));
        chk("pll_free", 16'(clk_ctrl.pll_free), 16'h0001);
        rd_chk(OFM_CFG_OFS, 16'h0000);
        repeat (200) @(posedge clk);
        #1;
        chk("fail", 16'(osc_fail), 16'h0000);
        stop_xtal();
        n = 0;
        while (osc_fail !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("detect", 16'(n >= 15 * TD + 3 && n <= 16 * TD + 8), 16'h0001);
        chk("irq", 16'(monitor_irq), 16'h0001);
        chk("gate_off", 16'(clk_ctrl.gate_off), 16'h0001);
        repeat (4) @(posedge clk);
        #1;
        chk("src", 16'(clk_ctrl.src), 16'(OFM_SRC_FREE));
        chk("gate_off", 16'(clk_ctrl.gate_off), 16'h0000);
        xrun <= 1'b1;
        repeat (100) @(posedge clk);
        #1;
        chk("src", 16'(clk_ctrl.src), 16'(OFM_SRC_FREE));
        rd_chk(OFM_STAT_OFS, 16'h003B);
        wr_reg(OFM_STAT_OFS, 16'h0002);
        chk("irq", 16'(monitor_irq), 16'h0000);
        chk("fail", 16'(osc_fail), 16'h0001);
        wr_reg(OFM_CFG_OFS, 16'h0010);
        chk("src", 16'(clk_ctrl.src), 16'(OFM_SRC_FREE));
        do_reset(OFM_STRAP_DIRECT, 1'b1);
        chk("src", 16'(clk_ctrl.src), 16'(OFM_SRC_DIRECT));
        chk("fail", 16'(osc_fail), 16'h0000);
        rd_chk(OFM_CFG_OFS, 16'h0000);
        // monitor off: pll powered down, crystal loss ignored
        wr_reg(OFM_CFG_OFS, 16'h0010);
        chk("pll_power", 16'(clk_ctrl.pll_power), 16'h0000);
        chk("pll_free", 16'(clk_ctrl.pll_free), 16'h0000);
        wr_reg(4'h2, 16'h0000);
        rd_chk(OFM_CFG_OFS, 16'h0010);
        rd_chk(4'h2, 16'h0000);
        stop_xtal();
        repeat (100) @(posedge clk);
        #1;
        chk("fail", 16'(osc_fail), 16'h0000);
        chk("src", 16'(clk_ctrl.src), 16'(OFM_SRC_DIRECT));
        xrun <= 1'b1;
        do_reset(OFM_STRAP_DIRECT, 1'b0);
        rd_chk(OFM_CFG_OFS, 16'h0000);
        chk("pll_power", 16'(clk_ctrl.pll_power), 16'h0001);
        // every strap code: source, factor, divider, monitor offered
        for (i = 0; i < 8; i++) begin
            xrun <= 1'b1;
            do_reset(3'(i), 1'b0);
            live = (exp_src(3'(i)) != OFM_SRC_PLL);
            chk("src", 16'(clk_ctrl.src), 16'(exp_src(3'(i))));
            chk("mult", 16'(clk_ctrl.mult), 16'(exp_mult(3'(i))));
            chk("post_div", 16'(clk_ctrl.post_div), 16'(OFM_POST_DIV));
            chk("pll_power", 16'(clk_ctrl.pll_power), 16'h0001);
            rd_chk(OFM_STAT_OFS, 16'({exp_mult(3'(i)), 1'b0, 3'(i), 4'h0}));
            stop_xtal();
            repeat (16 * TD + 40) @(posedge clk);
            #1;
            chk("fail", 16'(osc_fail), 16'(live));
        end
        end_of_test();
    end
endmodule
